// ---- cursor_pkg.sv ----
package cursor_pkg;
   // Geometry of the cursor image
   localparam int unsigned COORD_W = 11;
   localparam int unsigned OFFS_W = 6;
   localparam int unsigned SEG_W = 12;
   localparam int unsigned MASK_WORD_W = 16;
   localparam int unsigned ROW_W = 64;
   localparam int unsigned COLOR_W = 24;
   localparam int unsigned MEM_ADDR_W = 22;
   localparam logic [6:0] CUR_SIZE = 7'h40;
   localparam logic [1:0] STACK_LAST = 2'h2;
   localparam logic [2:0] FETCH_LAST = 3'h7;
   // Register byte addresses
   localparam logic [7:0] OFF_LOCK = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_STYLE = 8'h08;
   localparam logic [7:0] OFF_FG_STACK = 8'h0c;
   localparam logic [7:0] OFF_BG_STACK = 8'h10;
   localparam logic [7:0] OFF_X_HIGH = 8'h14;
   localparam logic [7:0] OFF_X_LOW = 8'h18;
   localparam logic [7:0] OFF_Y_HIGH = 8'h1c;
   localparam logic [7:0] OFF_Y_LOW = 8'h20;
   localparam logic [7:0] OFF_X_OFFSET = 8'h24;
   localparam logic [7:0] OFF_Y_OFFSET = 8'h28;
   localparam logic [7:0] OFF_START_HIGH = 8'h2c;
   localparam logic [7:0] OFF_START_LOW = 8'h30;
   localparam logic [7:0] OFF_ADV_FUNC = 8'h34;
   localparam logic [7:0] OFF_STATUS = 8'h38;
   // Field positions and key values
   localparam int unsigned STYLE_BIT = 4;
   localparam int unsigned MODE_EN_BIT = 0;
   localparam int unsigned ENHANCED_BIT = 0;
   localparam logic [7:0] KEY_UNLOCK = 8'ha0;
   localparam logic [7:0] KEY_LOCK = 8'h00;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [0:0] {
      FETCH_IDLE = 1'b0,
      FETCH_RUN = 1'b1
   } fetch_state_t;
endpackage : cursor_pkg

// ---- disp_mem_model.sv ----
`timescale 1ns/100ps
module disp_mem_model
   import cursor_pkg::*;
(
   // Clock
   input wire logic clock,
   // Fetch port
   input wire logic req,
   input wire logic [MEM_ADDR_W-1:0] addr,
   output logic ack,
   output logic [MASK_WORD_W-1:0] data
);
   logic [1:0] wait_cnt;
   logic slow;
   initial begin
      ack = 1'b0;
      data = 16'h0;
      wait_cnt = 2'h0;
      slow = 1'b0;
   end
   // Alternate prompt and slow answers; data toggles when not answering
   always @(posedge clock) begin
      ack <= 1'b0;
      data <= ~data;
      if (req && !ack) begin
         if (wait_cnt == 2'h0) begin
            ack <= 1'b1;
            // Columns with AND one and XOR zero are transparent padding in desktop style
            data <= addr[1] ? 16'hcccc : 16'hf0f0;
            wait_cnt <= slow ? 2'h0 : 2'h2;
            slow <= !slow;
         end else begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end
endmodule : disp_mem_model

// ---- hw_cursor_overlay.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Cursor is a fixed 64 by 64 image read from display memory.
// - Shape is two 512-byte masks, AND and XOR, interleaved word by word.
// - Style bit 4 picks desktop table (0) or window-system table (1).
// - AND/XOR pair picks background, foreground, screen or its inverse.
// - Foreground and background colors each stack three bytes.
// - Mode register read zeroes stack pointers; low byte written first.
// - Cursor forced off unless enhanced mode bit 0 is set.
// - Mode register bit 0 turns the cursor on or off.
// - Cursor registers writable only after key A0H; 00H relocks.
// - X and Y coordinates are 11 bits, 0 to 2047.
// - Pixels past right or bottom active edge are clipped.
// - Vertical skip count drops the first rows of the image.
// - Horizontal skip count drops the first columns of the image.
// - New position takes effect once per frame only.
// - Fetch alternates AND and XOR 16-bit words, indices 0 to 255.
// - Start address is a 12-bit 1024-byte segment number.
module hw_cursor_overlay
   import cursor_pkg::*;
#(
   parameter logic [COORD_W-1:0] H_ACTIVE = 11'd1024,
   parameter logic [COORD_W-1:0] V_ACTIVE = 11'd768
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // AXI4-Lite write channels
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read channels
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Display timing and screen pixel stream
   input wire logic FRAME_START,
   input wire logic LINE_START,
   input wire logic PIX_VALID,
   input wire logic [COORD_W-1:0] H_COUNT,
   input wire logic [COORD_W-1:0] V_COUNT,
   input wire logic [COLOR_W-1:0] SCREEN_PIXEL,
   output logic [COLOR_W-1:0] PIX_OUT,
   output logic PIX_OUT_VALID,
   // Display memory read port
   output logic MEM_REQ,
   output logic [MEM_ADDR_W-1:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic [MASK_WORD_W-1:0] MEM_DATA
);

   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);

   // Bus side state
   logic aw_held, w_held, bvalid, rvalid;
   logic [7:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb_q;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] lock_val;
   logic mode_en, style_sel, enhanced;
   logic [COLOR_W-1:0] fg_color, bg_color;
   logic [1:0] fg_ptr, bg_ptr;
   logic [COORD_W-1:0] cur_x, cur_y;
   logic [OFFS_W-1:0] cur_ox, cur_oy;
   logic [SEG_W-1:0] cur_seg;
   logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
   logic [7:0] next_awaddr_q, next_wdata_q, next_lock_val;
   logic next_wstrb_q;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic next_mode_en, next_style_sel, next_enhanced;
   logic [COLOR_W-1:0] next_fg_color, next_bg_color;
   logic [1:0] next_fg_ptr, next_bg_ptr;
   logic [COORD_W-1:0] next_cur_x, next_cur_y;
   logic [OFFS_W-1:0] next_cur_ox, next_cur_oy;
   logic [SEG_W-1:0] next_cur_seg;

   logic aw_hs, w_hs, wr_fire, ar_fire, unlocked, wr_mapped, rd_mapped;
   logic [7:0] wr_addr, wr_data;
   logic wr_en;
   logic [31:0] rd_word;

   // Display side state
   fetch_state_t fstate, next_fstate;
   logic [2:0] fetch_cnt, next_fetch_cnt;
   logic [5:0] fetch_row, next_fetch_row;
   logic [ROW_W-1:0] and_row, xor_row, next_and_row, next_xor_row;
   logic [COORD_W-1:0] disp_x, disp_y, next_disp_x, next_disp_y;
   logic [OFFS_W-1:0] disp_ox, disp_oy, next_disp_ox, next_disp_oy;
   logic [COLOR_W-1:0] next_pix;
   logic next_pix_valid;

   logic cursor_on, row_vis, col_vis, in_cursor, and_bit, xor_bit;
   logic [COORD_W-1:0] dy, dx;
   logic [OFFS_W-1:0] row, col;
   logic [6:0] row_span, col_span;

   assign S_AXI_AWREADY = !aw_held && !bvalid;
   assign S_AXI_WREADY = !w_held && !bvalid;
   assign S_AXI_ARREADY = !rvalid;
   assign S_AXI_BVALID = bvalid;
   assign S_AXI_BRESP = bresp;
   assign S_AXI_RVALID = rvalid;
   assign S_AXI_RRESP = rresp;
   assign S_AXI_RDATA = rdata;

   assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_fire = (aw_held || aw_hs) && (w_held || w_hs) && !bvalid;
   assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
   assign wr_addr = aw_held ? awaddr_q : S_AXI_AWADDR;
   assign wr_data = w_held ? wdata_q : S_AXI_WDATA[7:0];
   assign wr_en = w_held ? wstrb_q : S_AXI_WSTRB[0];
   assign unlocked = (lock_val == KEY_UNLOCK);
   assign wr_mapped = (wr_addr <= OFF_STATUS) && (wr_addr[1:0] == 2'b00);
   assign rd_mapped = (S_AXI_ARADDR <= OFF_STATUS)
      && (S_AXI_ARADDR[1:0] == 2'b00);

   always_comb begin
      rd_word = 32'h0000_0000;
      case (S_AXI_ARADDR)
         OFF_LOCK: rd_word[7:0] = lock_val;
         OFF_MODE: rd_word[MODE_EN_BIT] = mode_en;
         OFF_STYLE: rd_word[STYLE_BIT] = style_sel;
         OFF_FG_STACK: rd_word[COLOR_W-1:0] = fg_color;
         OFF_BG_STACK: rd_word[COLOR_W-1:0] = bg_color;
         OFF_X_HIGH: rd_word[2:0] = cur_x[COORD_W-1:8];
         OFF_X_LOW: rd_word[7:0] = cur_x[7:0];
         OFF_Y_HIGH: rd_word[2:0] = cur_y[COORD_W-1:8];
         OFF_Y_LOW: rd_word[7:0] = cur_y[7:0];
         OFF_X_OFFSET: rd_word[OFFS_W-1:0] = cur_ox;
         OFF_Y_OFFSET: rd_word[OFFS_W-1:0] = cur_oy;
         OFF_START_HIGH: rd_word[3:0] = cur_seg[SEG_W-1:8];
         OFF_START_LOW: rd_word[7:0] = cur_seg[7:0];
         OFF_ADV_FUNC: rd_word[ENHANCED_BIT] = enhanced;
         OFF_STATUS: rd_word[5:0] = {fg_ptr, bg_ptr, fstate == FETCH_RUN,
            cursor_on};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_awaddr_q = awaddr_q;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_lock_val = lock_val;
      next_mode_en = mode_en;
      next_style_sel = style_sel;
      next_enhanced = enhanced;
      next_fg_color = fg_color;
      next_bg_color = bg_color;
      next_fg_ptr = fg_ptr;
      next_bg_ptr = bg_ptr;
      next_cur_x = cur_x;
      next_cur_y = cur_y;
      next_cur_ox = cur_ox;
      next_cur_oy = cur_oy;
      next_cur_seg = cur_seg;
      if (aw_hs && !wr_fire) begin
         next_aw_held = 1'b1;
         next_awaddr_q = S_AXI_AWADDR;
      end
      if (w_hs && !wr_fire) begin
         next_w_held = 1'b1;
         next_wdata_q = S_AXI_WDATA[7:0];
         next_wstrb_q = S_AXI_WSTRB[0];
      end
      if (bvalid && S_AXI_BREADY) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_fire && wr_en) begin
         case (wr_addr)
            OFF_LOCK: next_lock_val = wr_data;
            OFF_ADV_FUNC: next_enhanced = wr_data[ENHANCED_BIT];
            default: next_lock_val = lock_val;
         endcase
         if (unlocked) begin
            case (wr_addr)
               OFF_MODE: next_mode_en = wr_data[MODE_EN_BIT];
               OFF_STYLE: next_style_sel = wr_data[STYLE_BIT];
               OFF_FG_STACK: begin
                  next_fg_color[fg_ptr*8 +: 8] = wr_data;
                  next_fg_ptr = (fg_ptr == STACK_LAST) ? 2'h0 : fg_ptr + 2'h1;
               end
               OFF_BG_STACK: begin
                  next_bg_color[bg_ptr*8 +: 8] = wr_data;
                  next_bg_ptr = (bg_ptr == STACK_LAST) ? 2'h0 : bg_ptr + 2'h1;
               end
               OFF_X_HIGH: next_cur_x[COORD_W-1:8] = wr_data[2:0];
               OFF_X_LOW: next_cur_x[7:0] = wr_data;
               OFF_Y_HIGH: next_cur_y[COORD_W-1:8] = wr_data[2:0];
               OFF_Y_LOW: next_cur_y[7:0] = wr_data;
               OFF_X_OFFSET: next_cur_ox = wr_data[OFFS_W-1:0];
               OFF_Y_OFFSET: next_cur_oy = wr_data[OFFS_W-1:0];
               OFF_START_HIGH: next_cur_seg[SEG_W-1:8] = wr_data[3:0];
               OFF_START_LOW: next_cur_seg[7:0] = wr_data;
               default: next_cur_seg = cur_seg;
            endcase
         end
      end
      if (rvalid && S_AXI_RREADY) begin
         next_rvalid = 1'b0;
      end
      if (ar_fire) begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
         if (S_AXI_ARADDR == OFF_MODE) begin
            next_fg_ptr = 2'h0;
            next_bg_ptr = 2'h0;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= RESET_BYTE;
         wdata_q <= RESET_BYTE;
         wstrb_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
         lock_val <= KEY_LOCK;
         mode_en <= 1'b0;
         style_sel <= 1'b0;
         enhanced <= 1'b0;
         fg_color <= '0;
         bg_color <= '0;
         fg_ptr <= 2'h0;
         bg_ptr <= 2'h0;
         cur_x <= '0;
         cur_y <= '0;
         cur_ox <= '0;
         cur_oy <= '0;
         cur_seg <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         lock_val <= next_lock_val;
         mode_en <= next_mode_en;
         style_sel <= next_style_sel;
         enhanced <= next_enhanced;
         fg_color <= next_fg_color;
         bg_color <= next_bg_color;
         fg_ptr <= next_fg_ptr;
         bg_ptr <= next_bg_ptr;
         cur_x <= next_cur_x;
         cur_y <= next_cur_y;
         cur_ox <= next_cur_ox;
         cur_oy <= next_cur_oy;
         cur_seg <= next_cur_seg;
      end
   end

   // Window geometry against the frame-latched position
   assign cursor_on = mode_en && enhanced;
   assign dy = V_COUNT - disp_y;
   assign dx = H_COUNT - disp_x;
   assign row_span = CUR_SIZE - {1'b0, disp_oy};
   assign col_span = CUR_SIZE - {1'b0, disp_ox};
   assign row_vis = (V_COUNT >= disp_y) && (dy < {4'h0, row_span});
   assign col_vis = (H_COUNT >= disp_x) && (dx < {4'h0, col_span});
   assign row = dy[OFFS_W-1:0] + disp_oy;
   assign col = dx[OFFS_W-1:0] + disp_ox;
   assign in_cursor = cursor_on && PIX_VALID && row_vis && col_vis
      && (H_COUNT < H_ACTIVE) && (V_COUNT < V_ACTIVE);
   assign and_bit = and_row[~col];
   assign xor_bit = xor_row[~col];

   assign MEM_REQ = (fstate == FETCH_RUN);
   assign MEM_ADDR = {cur_seg, fetch_row, fetch_cnt[2:1], fetch_cnt[0],
      1'b0};

   always_comb begin
      next_disp_x = disp_x;
      next_disp_y = disp_y;
      next_disp_ox = disp_ox;
      next_disp_oy = disp_oy;
      next_fstate = fstate;
      next_fetch_cnt = fetch_cnt;
      next_fetch_row = fetch_row;
      next_and_row = and_row;
      next_xor_row = xor_row;
      next_pix = SCREEN_PIXEL;
      next_pix_valid = PIX_VALID;
      if (FRAME_START) begin
         next_disp_x = cur_x;
         next_disp_y = cur_y;
         next_disp_ox = cur_ox;
         next_disp_oy = cur_oy;
      end
      case (fstate)
         FETCH_IDLE: begin
            if (LINE_START && cursor_on && row_vis) begin
               next_fstate = FETCH_RUN;
               next_fetch_cnt = 3'h0;
               next_fetch_row = row;
            end
         end
         FETCH_RUN: begin
            if (MEM_ACK) begin
               if (fetch_cnt[0]) begin
                  next_xor_row[(3 - fetch_cnt[2:1])*MASK_WORD_W +:
                     MASK_WORD_W] = MEM_DATA;
               end else begin
                  next_and_row[(3 - fetch_cnt[2:1])*MASK_WORD_W +:
                     MASK_WORD_W] = MEM_DATA;
               end
               next_fetch_cnt = fetch_cnt + 3'h1;
               if (fetch_cnt == FETCH_LAST) begin
                  next_fstate = FETCH_IDLE;
               end
            end
         end
         default: next_fstate = FETCH_IDLE;
      endcase
      if (in_cursor) begin
         case ({style_sel, and_bit, xor_bit})
            3'b000: next_pix = bg_color;
            3'b001: next_pix = fg_color;
            3'b010: next_pix = SCREEN_PIXEL;
            3'b011: next_pix = ~SCREEN_PIXEL;
            3'b110: next_pix = bg_color;
            3'b111: next_pix = fg_color;
            default: next_pix = SCREEN_PIXEL;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         disp_x <= '0;
         disp_y <= '0;
         disp_ox <= '0;
         disp_oy <= '0;
         fstate <= FETCH_IDLE;
         fetch_cnt <= 3'h0;
         fetch_row <= 6'h00;
         and_row <= '0;
         xor_row <= '0;
         PIX_OUT <= '0;
         PIX_OUT_VALID <= 1'b0;
      end else begin
         disp_x <= next_disp_x;
         disp_y <= next_disp_y;
         disp_ox <= next_disp_ox;
         disp_oy <= next_disp_oy;
         fstate <= next_fstate;
         fetch_cnt <= next_fetch_cnt;
         fetch_row <= next_fetch_row;
         and_row <= next_and_row;
         xor_row <= next_xor_row;
         PIX_OUT <= next_pix;
         PIX_OUT_VALID <= next_pix_valid;
      end
   end

   chk_lock_blocks_write: assert property (
      wr_fire && !unlocked && wr_addr == OFF_X_LOW |=> $stable(cur_x))
      else $error("locked write changed cursor x");
   chk_mode_read_clear: assert property (
      ar_fire && S_AXI_ARADDR == OFF_MODE
      |=> fg_ptr == 2'h0 && bg_ptr == 2'h0)
      else $error("mode read did not clear stack pointers");
   chk_enable_write: assert property (
      wr_fire && wr_en && unlocked && wr_addr == OFF_MODE
      |=> mode_en == $past(wr_data[MODE_EN_BIT]))
      else $error("cursor enable not taken from mode write");
   chk_vga_forces_off: assert property (
      !enhanced |-> !in_cursor && !MEM_REQ ##1 !enhanced |-> !in_cursor)
      else $error("cursor active outside enhanced mode");
   chk_pos_frame_only: assert property (
      !FRAME_START |=> $stable(disp_x) && $stable(disp_y))
      else $error("displayed position changed mid frame");
   chk_clip_edge: assert property (
      in_cursor |-> H_COUNT < H_ACTIVE && V_COUNT < V_ACTIVE
      && dy < 11'd64 && dx < 11'd64)
      else $error("cursor pixel outside active area");
   chk_skip_cols: assert property (
      in_cursor |-> col >= disp_ox && row >= disp_oy)
      else $error("skipped cursor row or column shown");
   chk_fetch_pairs: assert property (
      MEM_REQ && MEM_ACK && !fetch_cnt[0] |=> MEM_REQ && fetch_cnt[0]
      && MEM_ADDR[1:0] == 2'b10 && $stable(MEM_ADDR[MEM_ADDR_W-1:3]))
      else $error("XOR word did not follow AND word");
   chk_desktop_invert: assert property (
      in_cursor && !style_sel && and_bit && xor_bit
      |=> PIX_OUT == ~$past(SCREEN_PIXEL))
      else $error("desktop style did not invert screen");
   chk_xwin_transparent: assert property (
      in_cursor && style_sel && !and_bit |=> PIX_OUT == $past(SCREEN_PIXEL))
      else $error("window style not transparent");
   chk_bresp_holds: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");

endmodule : hw_cursor_overlay

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import cursor_pkg::*;
   localparam logic [23:0] FG = 24'h332211;
   localparam logic [23:0] BG = 24'h776655;
   localparam logic [23:0] SCR = 24'h123456;
   localparam logic [15:0] PAT_AND = 16'hf0f0;
   localparam logic [15:0] PAT_XOR = 16'hcccc;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic fs, ls, pv, pov, mreq, mack;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [COORD_W-1:0] hc, vc;
   logic [COLOR_W-1:0] scr, pout;
   logic [MEM_ADDR_W-1:0] maddr;
   logic [MASK_WORD_W-1:0] mdata;
   logic [MEM_ADDR_W-1:0] addr_q[$];
   int bad_count, checks, cycles;

   hw_cursor_overlay DUT (
      .CLOCK(clk), .RST(rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .FRAME_START(fs), .LINE_START(ls), .PIX_VALID(pv), .H_COUNT(hc),
      .V_COUNT(vc), .SCREEN_PIXEL(scr), .PIX_OUT(pout),
      .PIX_OUT_VALID(pov), .MEM_REQ(mreq), .MEM_ADDR(maddr),
      .MEM_ACK(mack), .MEM_DATA(mdata)
   );
   disp_mem_model MEM (.clock(clk), .req(mreq), .addr(maddr), .ack(mack),
      .data(mdata));

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (mreq && mack) addr_q.push_back(maddr);
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'h0, {30'h0, bresp});
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
   endtask : rdr

   function automatic logic [23:0] mix(input int col, input logic st);
      logic a, x;
      if (col < 0 || col > 63) return SCR;
      a = PAT_AND[15 - col % 16];
      x = PAT_XOR[15 - col % 16];
      if (!st) return a ? (x ? ~SCR : SCR) : (x ? FG : BG);
      return a ? (x ? FG : BG) : SCR;
   endfunction : mix

   task automatic pix(input int h, input int col, input logic st);
      @(posedge clk);
      pv <= 1'b1;
      hc <= h[10:0];
      vc <= 11'h7;
      scr <= SCR;
      repeat (2) @(posedge clk);
      chk("pix_out", {8'h0, mix(col, st)}, {8'h0, pout});
      chk("pix_valid", 32'h1, {31'h0, pov});
      pv <= 1'b0;
   endtask : pix

   task automatic pulse(input logic frame);
      @(posedge clk);
      if (frame) fs <= 1'b1;
      else ls <= 1'b1;
      vc <= 11'h7;
      @(posedge clk);
      fs <= 1'b0;
      ls <= 1'b0;
   endtask : pulse

   task automatic on_is(input logic [31:0] e);
      rdr(OFF_STATUS);
      chk("cursor_on", e, rd & 32'h1);
   endtask : on_is

   task automatic t_lock;
      wr(OFF_X_LOW, 32'h55);
      rdr(OFF_X_LOW);
      chk("x_low", 32'h0, rd);
      wr(OFF_LOCK, {24'h0, KEY_UNLOCK});
      wr(OFF_X_HIGH, 32'hff);
      rdr(OFF_X_HIGH);
      chk("x_high", 32'h7, rd);
      wr(OFF_LOCK, {24'h0, KEY_LOCK});
      wr(OFF_X_HIGH, 32'h0);
      rdr(OFF_X_HIGH);
      chk("x_high", 32'h7, rd);
      rdr(8'h3c);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
      wr(OFF_LOCK, {24'h0, KEY_UNLOCK});
      wr(OFF_X_HIGH, 32'h0);
   endtask : t_lock

   task automatic t_stack;
      rdr(OFF_MODE);
      for (int i = 0; i < 3; i++) wr(OFF_FG_STACK, {24'h0, FG[8*i +: 8]});
      rdr(OFF_FG_STACK);
      chk("fg_color", {8'h0, FG}, rd);
      wr(OFF_BG_STACK, 32'h99);
      rdr(OFF_STATUS);
      chk("stack_ptrs", 32'h4, rd & 32'h3c);
      rdr(OFF_MODE);
      rdr(OFF_STATUS);
      chk("stack_ptrs", 32'h0, rd & 32'h3c);
      for (int i = 0; i < 3; i++) wr(OFF_BG_STACK, {24'h0, BG[8*i +: 8]});
      rdr(OFF_BG_STACK);
      chk("bg_color", {8'h0, BG}, rd);
   endtask : t_stack

   task automatic t_enable;
      wr(OFF_MODE, 32'h1);
      on_is(32'h0);
      wr(OFF_ADV_FUNC, 32'h1);
      on_is(32'h1);
      wr(OFF_MODE, 32'h0);
      on_is(32'h0);
      wr(OFF_MODE, 32'h1);
   endtask : t_enable

   task automatic t_draw;
      wr(OFF_X_LOW, 32'h64);
      wr(OFF_Y_LOW, 32'h5);
      wr(OFF_X_OFFSET, 32'h2);
      wr(OFF_Y_OFFSET, 32'h3);
      wr(OFF_START_HIGH, 32'h3);
      wr(OFF_START_LOW, 32'hfe);
      pulse(1'b1);
      pulse(1'b0);
      repeat (100) if (addr_q.size() < 8) @(posedge clk);
      chk("fetch_cnt", 32'h8, 32'(addr_q.size()));
      for (int k = 0; k < 8; k++) begin
         chk("mem_addr", 32'h000ff850 + 32'((k / 2) * 4 + (k % 2) * 2),
            {10'h0, addr_q[k]});
      end
      for (int st = 0; st < 2; st++) begin
         wr(OFF_STYLE, st ? 32'h10 : 32'h0);
         for (int c = 1; c < 9; c++) begin
            pix(c + 98, c < 2 ? -1 : c, st[0]);
         end
      end
   endtask : t_draw

   task automatic t_clip;
      wr(OFF_Y_HIGH, 32'h3);
      wr(OFF_Y_LOW, 32'h0);
      pix(100, 2, 1'b1);
      addr_q.delete();
      pulse(1'b1);
      pulse(1'b0);
      repeat (40) @(posedge clk);
      chk("fetch_cnt", 32'h0, 32'(addr_q.size()));
      pix(100, -1, 1'b1);
      // Cursor straddling the right edge of the active area
      wr(OFF_Y_HIGH, 32'h0);
      wr(OFF_Y_LOW, 32'h5);
      wr(OFF_X_HIGH, 32'h3);
      wr(OFF_X_LOW, 32'hfc);
      pulse(1'b1);
      pulse(1'b0);
      repeat (100) if (addr_q.size() < 8) @(posedge clk);
      chk("fetch_cnt", 32'h8, 32'(addr_q.size()));
      pix(1020, 2, 1'b1);
      pix(1026, -1, 1'b1);
   endtask : t_clip

   task automatic tally_and_finish;
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, fs, ls, pv} = 8'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      hc = 11'h0;
      vc = 11'h0;
      scr = 24'h0;
      bad_count = 0;
      checks = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_lock();
      t_stack();
      t_enable();
      t_draw();
      t_clip();
      tally_and_finish();
   end
endmodule : tb_top
